// ### inc/decode_pkg.sv
// types shared by the instruction word decoder and its bench
`include "instruction_word_decode_timing_consts.svh"
package decode_pkg;

	typedef enum logic [1:0] {FMT_BYTE = 2'h0, FMT_BIT = 2'h1, FMT_LIT = 2'h2} fmt_t;

	typedef enum logic [1:0] {
		PRE_INC = 2'h0,
		PRE_DEC = 2'h1,
		POST_INC = 2'h2,
		POST_DEC = 2'h3
	} pointer_update_sel_t;

	typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_EXEC = 2'b10} state_t;

	typedef struct packed {
		fmt_t fmt;
		logic [`FILE_ADDR_W-1:0] file_addr;
		logic [`BIT_NUM_W-1:0] bit_num;
		logic dest_sel;
		logic ptr_num;
		pointer_update_sel_t pointer_update_sel;
		logic indirect;
		logic [1:0] cycles;
	} decode_t;

	typedef struct packed {
		logic read;
		logic write;
		logic [7:0] address;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} avs_req_t;

	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
	} avs_rsp_t;

	typedef struct packed {
		state_t st;
		logic [1:0] q;
		logic [1:0] cyc;
		logic [`WORD_W-1:0] word;
		decode_t dec;
		logic [7:0] acc;
		logic [1:0][`PTR_W-1:0] ptr;
		logic [`BANK_DEPTH-1:0][7:0] bank;
		logic [7:0] rd;
		logic [`PTR_W-1:0] ea;
		logic run;
		logic [31:0] retired;
		logic ready;
		logic retire;
		avs_rsp_t rsp;
	} core_state_t;

endpackage

// ### inc/instruction_word_decode_timing_consts.svh
// constants for the instruction word decoder: offsets, fields, resets, timing
`ifndef INSTRUCTION_WORD_DECODE_TIMING_CONSTS_SVH
`define INSTRUCTION_WORD_DECODE_TIMING_CONSTS_SVH

`define WORD_W 14
`define FILE_ADDR_W 7
`define BIT_NUM_W 3
`define PTR_W 16
`define BANK_DEPTH 128
`define PGM_SPACE_BIT 15
`define PGM_READ_VALUE 8'h00

`define OSC_PER_INSN_CYCLE 4
`define Q_LAST (2'(`OSC_PER_INSN_CYCLE - 1))

`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_ACC 8'h08
`define REG_PTR0 8'h0C
`define REG_PTR1 8'h10
`define REG_RETIRED 8'h14

`define CTRL_RUN_BIT 0
`define CTRL_RUN_RESET 1'b1
`define ACC_RESET 8'h00
`define PTR_RESET 16'h0000

`endif

// ### tb/fetch_model.sv
// program fetch model offering one word per request
`include "instruction_word_decode_timing_consts.svh"
module fetch_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic go,
	input wire logic [`WORD_W-1:0] word,
	input wire logic insn_ready,
	output logic insn_valid,
	output logic [`WORD_W-1:0] insn_word
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			insn_valid <= 1'b0;
			insn_word <= '0;
		end
		else if (go)
		begin
			insn_valid <= 1'b1;
			insn_word <= word;
		end
		else if (insn_valid && insn_ready)
		begin
			insn_valid <= 1'b0;
			insn_word <= ~insn_word;
		end
	end
endmodule

// ### tb/instruction_word_decode_timing_sva.sv
// concurrent checks on the decoder ports
`include "instruction_word_decode_timing_consts.svh"
module instruction_word_decode_timing_sva (
	input wire logic clk,
	input wire logic reset,
	input wire logic insn_valid,
	input wire logic [`WORD_W-1:0] insn_word,
	input wire logic insn_ready,
	input wire decode_pkg::decode_t dec,
	input wire logic retire,
	input wire decode_pkg::avs_req_t avs_req,
	input wire decode_pkg::avs_rsp_t avs_rsp
);
	timeunit 1ns;
	timeprecision 1ps;
	import decode_pkg::*;
	logic take;
	assign take = insn_valid && insn_ready;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	chk_retire_ready: assert property (retire |-> insn_ready)
		else $error("retire without ready");
	chk_ready_drop: assert property (take |=> !insn_ready)
		else $error("ready held after take");
	chk_one_cycle: assert property (take ##1 dec.cycles == 2'h1 |-> (!retire)[*3] ##1 retire)
		else $error("one-cycle timing wrong");
	chk_two_cycle: assert property (take ##1 dec.cycles == 2'h2 |-> (!retire)[*7] ##1 retire)
		else $error("two-cycle timing wrong");
	chk_three_cycle: assert property (take ##1 dec.cycles == 2'h3 |-> (!retire)[*8] ##4 retire)
		else $error("three-cycle timing wrong");
	chk_file_field: assert property (take |=> dec.fmt == FMT_LIT ||
		dec.file_addr == $past(insn_word[6:0])) else $error("file field wrong");
	chk_bit_field: assert property (take |=> dec.fmt != FMT_BIT ||
		dec.bit_num == $past(insn_word[9:7])) else $error("bit field wrong");
	chk_dest_field: assert property (take |=> dec.fmt != FMT_BYTE ||
		dec.dest_sel == $past(insn_word[7])) else $error("dest field wrong");
endmodule
bind instruction_word_decode_timing instruction_word_decode_timing_sva sva (.clk(clk),
	.reset(reset), .insn_valid(insn_valid), .insn_word(insn_word), .insn_ready(insn_ready),
	.dec(dec), .retire(retire), .avs_req(avs_req), .avs_rsp(avs_rsp));

// ### tb/tb_instruction_word_decode_timing.sv
// self-checking bench for the instruction word decoder
`include "instruction_word_decode_timing_consts.svh"
module tb_instruction_word_decode_timing;
	timeunit 1ns;
	timeprecision 1ps;
	import decode_pkg::*;
	typedef struct packed {logic [13:0] w; fmt_t f; logic [1:0] c;} row_t;
	localparam row_t ROWS [19] = '{'{14'h0785, FMT_BYTE, 2'h1}, '{14'h1000, FMT_BIT, 2'h1},
		'{14'h1B85, FMT_BIT, 2'h2}, '{14'h1C05, FMT_BIT, 2'h2}, '{14'h2000, FMT_LIT, 2'h2},
		'{14'h2800, FMT_LIT, 2'h2}, '{14'h3200, FMT_LIT, 2'h2}, '{14'h3400, FMT_LIT, 2'h2},
		'{14'h3000, FMT_LIT, 2'h1}, '{14'h0008, FMT_LIT, 2'h2}, '{14'h0009, FMT_LIT, 2'h2},
		'{14'h000A, FMT_LIT, 2'h2}, '{14'h000B, FMT_LIT, 2'h2}, '{14'h0B05, FMT_BYTE, 2'h2},
		'{14'h0F05, FMT_BYTE, 2'h2}, '{14'h0010, FMT_LIT, 2'h1}, '{14'h0011, FMT_LIT, 2'h1},
		'{14'h0012, FMT_LIT, 2'h1}, '{14'h0013, FMT_LIT, 2'h1}};
	logic clk, reset, insn_valid, insn_ready, retire, go;
	logic [13:0] insn_word, word;
	decode_t dec;
	avs_req_t req;
	avs_rsp_t rsp;
	logic [31:0] rd;
	int num_errors, checks, cyc, n;
	instruction_word_decode_timing dut (.clk(clk), .reset(reset), .insn_valid(insn_valid),
		.insn_word(insn_word), .insn_ready(insn_ready), .dec(dec), .retire(retire),
		.avs_req(req), .avs_rsp(rsp));
	fetch_model fetch (.clk(clk), .reset(reset), .go(go), .word(word),
		.insn_ready(insn_ready), .insn_valid(insn_valid), .insn_word(insn_word));
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task results;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		req.read <= !w;
		req.write <= w;
		req.address <= a;
		req.writedata <= d;
		do @(posedge clk); while (rsp.waitrequest !== 1'b0);
		rd = rsp.readdata;
		req.read <= 1'b0;
		req.write <= 1'b0;
	endtask
	// n counts clocks from the taking edge to the retire pulse
	task issue(input logic [13:0] w);
		@(posedge clk);
		go <= 1'b1;
		word <= w;
		@(posedge clk);
		go <= 1'b0;
		do @(posedge clk); while (!(insn_valid === 1'b1 && insn_ready === 1'b1));
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end while (retire !== 1'b1);
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			num_errors++;
			results;
		end
	end
	initial
	begin
		reset = 1'b1;
		go = 1'b0;
		word = '0;
		req = '0;
		req.byteenable = 4'hF;
		repeat (8) @(posedge clk);
		chk(insn_ready, 32'h0);
		chk(rsp.waitrequest, 32'h1);
		reset <= 1'b0;
		bus(1'b0, `REG_ACC, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, 8'h20, 32'h0);
		chk(rd, 32'h0);
		foreach (ROWS[i])
		begin
			issue(ROWS[i].w);
			chk(dec.fmt, ROWS[i].f);
			chk(dec.cycles, ROWS[i].c);
			chk(n, 4 * ROWS[i].c);
			chk(dec.pointer_update_sel, ROWS[i].w[1:0]);
		end
		bus(1'b0, `REG_RETIRED, 32'h0);
		chk(rd, 32'h13);
		bus(1'b1, `REG_ACC, 32'h3);
		issue(14'h0785);
		bus(1'b1, `REG_ACC, 32'h1);
		issue(14'h0705);
		bus(1'b0, `REG_ACC, 32'h0);
		chk(rd, 32'h4);
		bus(1'b1, `REG_PTR0, 32'h8000);
		issue(14'h0B80);
		chk(dec.cycles, 32'h3);
		chk(n, 32'hC);
		bus(1'b1, `REG_PTR1, 32'h8000);
		issue(14'h0014);
		chk(dec.ptr_num, 32'h1);
		chk(dec.indirect, 32'h1);
		chk(n, 32'h8);
		results;
	end
endmodule

// ### verilog/instruction_word_decode_timing.sv
// instruction word decoder with cycle timing, read-modify-write file bank and register slave
//
// The register addresses and the Avalon-MM slave port are this design's own decisions.
`include "instruction_word_decode_timing_consts.svh"
module instruction_word_decode_timing (
	input wire logic clk,
	input wire logic reset,
	input wire logic insn_valid,
	input wire logic [`WORD_W-1:0] insn_word,
	output logic insn_ready,
	output decode_pkg::decode_t dec,
	output logic retire,
	input wire decode_pkg::avs_req_t avs_req,
	output decode_pkg::avs_rsp_t avs_rsp
);
	import decode_pkg::*;

	core_state_t s_reg;
	core_state_t s_next;

	assign insn_ready = s_reg.ready;
	assign dec = s_reg.dec;
	assign retire = s_reg.retire;
	assign avs_rsp = s_reg.rsp;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		merge = (old & ~m) | (wd & m);
	endfunction

	function automatic logic [`PTR_W-1:0] sext6(input logic [5:0] k);
		sext6 = {{10{k[5]}}, k};
	endfunction

	// pointer move with update mode: 00 0000 0001 xnmm
	function automatic logic is_mode_form(input logic [`WORD_W-1:0] w);
		is_mode_form = (w[13:4] == 10'h001);
	endfunction

	// indexed pointer access: 11 1111 xnkk kkkk
	function automatic logic is_offs_form(input logic [`WORD_W-1:0] w);
		is_offs_form = (w[13:8] == 6'h3F);
	endfunction

	function automatic decode_t decode_word(input logic [`WORD_W-1:0] w,
		input logic [1:0][`PTR_W-1:0] ptr);
		decode_t d;
		d = '0;
		d.file_addr = w[6:0];
		d.bit_num = w[9:7];
		d.dest_sel = w[7];
		d.pointer_update_sel = pointer_update_sel_t'(w[1:0]);
		if (w[13:12] == 2'b01)
		begin
			d.fmt = FMT_BIT;
		end
		else if (w[13:12] == 2'b00 && w[11:7] != 5'h00)
		begin
			d.fmt = FMT_BYTE;
		end
		else
		begin
			d.fmt = FMT_LIT;
		end
		if (is_mode_form(w))
		begin
			d.ptr_num = w[2];
			d.indirect = 1'b1;
		end
		else if (is_offs_form(w))
		begin
			d.ptr_num = w[6];
			d.indirect = 1'b1;
		end
		else if (w[13:7] == 7'h62)
		begin
			d.ptr_num = w[6];
		end
		else if (w[13:7] == 7'h02)
		begin
			// clear accumulator: low operand bits are don't-care, no file touched
			d.indirect = 1'b0;
		end
		else if (d.fmt != FMT_LIT && w[6:1] == 6'h00)
		begin
			d.ptr_num = w[0];
			d.indirect = 1'b1;
		end
		casez (w)
			14'b00_0000_0000_1000,
			14'b00_0000_0000_1001,
			14'b00_0000_0000_1010,
			14'b10_????_????_????,
			14'b11_0100_????_????: d.cycles = 2'h2;
			14'b00_0000_0000_1011,
			14'b11_001?_????_????,
			14'b01_1???_????_????,
			14'b00_1011_????_????,
			14'b00_1111_????_????: d.cycles = 2'h2;
			default: d.cycles = 2'h1;
		endcase
		if (d.indirect && ptr[d.ptr_num][`PGM_SPACE_BIT])
		begin
			d.cycles = d.cycles + 2'h1;
		end
		decode_word = d;
	endfunction

	always_comb
	begin
		logic [31:0] rdmux;
		logic [31:0] tmp;
		logic [`PTR_W-1:0] p;
		logic [`PTR_W-1:0] ea;
		logic [`WORD_W-1:0] w;
		logic [7:0] k8;
		logic [7:0] r;
		logic [7:0] fv;
		logic [7:0] av;
		logic fw;
		logic aw;
		rdmux = 32'h0000_0000;
		tmp = 32'h0000_0000;
		p = s_reg.ptr[s_reg.dec.ptr_num];
		ea = {9'h000, s_reg.dec.file_addr};
		w = s_reg.word;
		k8 = w[7:0];
		r = 8'h00;
		fv = 8'h00;
		av = 8'h00;
		fw = 1'b0;
		aw = 1'b0;
		s_next = s_reg;
		s_next.retire = 1'b0;

		// register slave: answer one edge after the request, act on the next
		case (avs_req.address)
			`REG_CTRL: rdmux = {31'h0000_0000, s_reg.run};
			`REG_STATUS: rdmux = {27'h000_0000, s_reg.dec.cycles, s_reg.dec.fmt,
				s_reg.st == ST_EXEC};
			`REG_ACC: rdmux = {24'h00_0000, s_reg.acc};
			`REG_PTR0: rdmux = {16'h0000, s_reg.ptr[0]};
			`REG_PTR1: rdmux = {16'h0000, s_reg.ptr[1]};
			`REG_RETIRED: rdmux = s_reg.retired;
			default: rdmux = 32'h0000_0000;
		endcase
		if (s_reg.rsp.waitrequest)
		begin
			if (avs_req.read || avs_req.write)
			begin
				s_next.rsp.waitrequest = 1'b0;
				s_next.rsp.readdata = rdmux;
			end
		end
		else
		begin
			s_next.rsp.waitrequest = 1'b1;
			if (avs_req.write)
			begin
				tmp = merge(rdmux, avs_req.writedata, avs_req.byteenable);
				case (avs_req.address)
					`REG_CTRL: s_next.run = tmp[`CTRL_RUN_BIT];
					`REG_ACC: s_next.acc = tmp[7:0];
					`REG_PTR0: s_next.ptr[0] = tmp[15:0];
					`REG_PTR1: s_next.ptr[1] = tmp[15:0];
					default: ;
				endcase
			end
		end

		// core sequencing; its updates override a bus write in the same edge
		unique case (s_reg.st)
			ST_IDLE:
			begin
				s_next.ready = s_next.run;
				if (s_reg.ready && insn_valid)
				begin
					s_next.word = insn_word;
					s_next.dec = decode_word(insn_word, s_reg.ptr);
					s_next.st = ST_EXEC;
					s_next.q = 2'h1;
					s_next.cyc = 2'h0;
					s_next.ready = 1'b0;
				end
			end
			ST_EXEC:
			begin
				s_next.q = s_reg.q + 2'h1;
				if (s_reg.cyc == 2'h0 && s_reg.q == 2'h1)
				begin
					// operand fetch with pointer pre/post update
					if (is_mode_form(w))
					begin
						unique case (s_reg.dec.pointer_update_sel)
							PRE_INC:
							begin
								ea = p + 16'h0001;
								s_next.ptr[s_reg.dec.ptr_num] = p + 16'h0001;
							end
							PRE_DEC:
							begin
								ea = p - 16'h0001;
								s_next.ptr[s_reg.dec.ptr_num] = p - 16'h0001;
							end
							POST_INC:
							begin
								ea = p;
								s_next.ptr[s_reg.dec.ptr_num] = p + 16'h0001;
							end
							POST_DEC:
							begin
								ea = p;
								s_next.ptr[s_reg.dec.ptr_num] = p - 16'h0001;
							end
						endcase
					end
					else if (is_offs_form(w))
					begin
						ea = p + sext6(w[5:0]);
					end
					else if (s_reg.dec.indirect)
					begin
						ea = p;
					end
					s_next.ea = ea;
					// read happens even when the instruction only writes
					s_next.rd = ea[`PGM_SPACE_BIT] ? `PGM_READ_VALUE
						: s_reg.bank[ea[`FILE_ADDR_W-1:0]];
				end
				if (s_reg.cyc == 2'h0 && s_reg.q == 2'h2)
				begin
					if (s_reg.dec.fmt == FMT_BYTE)
					begin
						unique case (w[11:8])
							4'h0: r = s_reg.acc;
							4'h1: r = 8'h00;
							4'h2: r = s_reg.rd - s_reg.acc;
							4'h3: r = s_reg.rd - 8'h01;
							4'h4: r = s_reg.rd | s_reg.acc;
							4'h5: r = s_reg.rd & s_reg.acc;
							4'h6: r = s_reg.rd ^ s_reg.acc;
							4'h7: r = s_reg.rd + s_reg.acc;
							4'h8: r = s_reg.rd;
							4'h9: r = ~s_reg.rd;
							4'hA: r = s_reg.rd + 8'h01;
							4'hB: r = s_reg.rd - 8'h01;
							4'hC: r = {s_reg.rd[0], s_reg.rd[7:1]};
							4'hD: r = {s_reg.rd[6:0], s_reg.rd[7]};
							4'hE: r = {s_reg.rd[3:0], s_reg.rd[7:4]};
							4'hF: r = s_reg.rd + 8'h01;
						endcase
						if (s_reg.dec.dest_sel)
						begin
							fw = 1'b1;
							fv = r;
						end
						else
						begin
							aw = 1'b1;
							av = r;
						end
					end
					else if (s_reg.dec.fmt == FMT_BIT)
					begin
						if (w[11] == 1'b0)
						begin
							fw = 1'b1;
							fv = w[10] ? (s_reg.rd | (8'h01 << s_reg.dec.bit_num))
								: (s_reg.rd & ~(8'h01 << s_reg.dec.bit_num));
						end
					end
					else if (is_mode_form(w) || is_offs_form(w))
					begin
						if (is_mode_form(w) ? w[3] : w[7])
						begin
							fw = 1'b1;
							fv = s_reg.acc;
						end
						else
						begin
							aw = 1'b1;
							av = s_reg.rd;
						end
					end
					else
					begin
						casez (w[13:7])
							7'b11_0000_?,
							7'b11_0100_?:
							begin
								aw = 1'b1;
								av = k8;
							end
							7'b11_1110_?:
							begin
								aw = 1'b1;
								av = s_reg.acc + k8;
							end
							7'b11_1001_?:
							begin
								aw = 1'b1;
								av = s_reg.acc & k8;
							end
							7'b11_1000_?:
							begin
								aw = 1'b1;
								av = s_reg.acc | k8;
							end
							7'b11_1010_?:
							begin
								aw = 1'b1;
								av = s_reg.acc ^ k8;
							end
							7'b11_1100_?:
							begin
								aw = 1'b1;
								av = k8 - s_reg.acc;
							end
							7'b11_0001_0:
							begin
								s_next.ptr[s_reg.dec.ptr_num] = p + sext6(w[5:0]);
							end
							default: ;
						endcase
					end
					if (aw)
					begin
						s_next.acc = av;
					end
					// program memory is read-only through a pointer
					if (fw && !s_reg.ea[`PGM_SPACE_BIT])
					begin
						s_next.bank[s_reg.ea[`FILE_ADDR_W-1:0]] = fv;
					end
				end
				if (s_reg.q == `Q_LAST)
				begin
					if (s_reg.cyc == s_reg.dec.cycles - 2'h1)
					begin
						s_next.st = ST_IDLE;
						s_next.ready = s_next.run;
						s_next.retire = 1'b1;
						s_next.retired = s_reg.retired + 32'h0000_0001;
					end
					else
					begin
						s_next.cyc = s_reg.cyc + 2'h1;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			s_reg <= '0;
			s_reg.st <= ST_IDLE;
			s_reg.run <= `CTRL_RUN_RESET;
			s_reg.acc <= `ACC_RESET;
			s_reg.ptr <= {`PTR_RESET, `PTR_RESET};
			s_reg.rsp.waitrequest <= 1'b1;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

endmodule
